// ### rtl/endpoint_command_control.sv
// Overview of operation
// R1 - Setup-busy on: setup on control endpoint marks enabled directions busy
// R2 - Setup-busy disabled: setup packet leaves endpoint control unchanged
// R3 - Iso size code 00=1023, 01=504, 10/11=248 bytes
// R4 - Firmware writes zero to reserved bits 7:3 of control two
// R5 - Each command write changes one field, no read-modify-write
// R6 - Firmware may write a constant with endpoint ORed in
// R7 - Bit 7 high targets transmit fields, low targets receive fields
// R8 - Code 000 disables the direction; no handshake sent
// R9 - Code 001 answers IN with STALL
// R10 - Code 010 normal: ACK with queued data, else NAK
// R11 - Code 011 answers every IN with NAK
// R12 - Code 100 clears toggle, code 101 sets toggle
// R13 - Code 110 clears iso flag, code 111 sets it
// R14 - Low four command bits select endpoint 0 to 15
//
// Implementation choice: the strobed register port.
`timescale 1ns/1ps
`include "ep_cmd_consts.svh"
module endpoint_command_control #(
  parameter int NUM_EP = 16
) (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic setup_rcvd,
  input wire logic [3:0] setup_ep,
  input wire logic in_token,
  input wire logic [3:0] in_ep,
  input wire logic in_queue_has_data,
  output logic [1:0] in_handshake,
  output logic [10:0] iso_max_payload,
  output logic [NUM_EP-1:0] tx_busy,
  output logic [NUM_EP-1:0] rx_busy,
  output ep_cmd_pkg::dir_ctl_s [NUM_EP-1:0] tx_ctl,
  output ep_cmd_pkg::dir_ctl_s [NUM_EP-1:0] rx_ctl
);
  // Four-bit endpoint field cannot serve any other count
  if (NUM_EP != 16)
  begin : g_bad_num_ep
    $error("NUM_EP must be 16 for a four-bit endpoint field");
  end

  logic [7:0] ctl_two_r, ctl_two_nxt;
  logic [7:0] cmd_r, cmd_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [1:0] hs_r, hs_nxt;
  logic [10:0] iso_r, iso_nxt;
  logic [NUM_EP-1:0] txb_r, txb_nxt, rxb_r, rxb_nxt;
  ep_cmd_pkg::dir_ctl_s [NUM_EP-1:0] tx_r, tx_nxt, rx_r, rx_nxt;

  logic wr_ctl_two, wr_cmd;
  logic [3:0] sel_ep;
  logic cmd_dir;
  ep_cmd_pkg::ep_cmd_e cmd_code;
  assign wr_ctl_two = reg_wr && reg_addr == `ADDR_ENGINE_CONTROL_TWO;
  assign wr_cmd = reg_wr && reg_addr == `ADDR_ENDPOINT_COMMAND;
  assign sel_ep = reg_wdata[3:0]; // R14
  assign cmd_dir = reg_wdata[`POS_DIR]; // R7
  assign cmd_code = ep_cmd_pkg::ep_cmd_e'(reg_wdata[`POS_CMD_LO +: 3]);

  // Apply one command to one direction's control set
  function automatic ep_cmd_pkg::dir_ctl_s apply_cmd(
    input ep_cmd_pkg::dir_ctl_s cur,
    input ep_cmd_pkg::ep_cmd_e code
  );
    ep_cmd_pkg::dir_ctl_s res;
    res = cur;
    case (code)
      ep_cmd_pkg::CMD_DISABLE:
      begin
        res.enable = 1'b0; // R8
        res.halt = 1'b0;
        res.force_nak = 1'b0;
      end
      ep_cmd_pkg::CMD_HALT:
      begin
        res.enable = 1'b1; // R9
        res.halt = 1'b1;
        res.force_nak = 1'b0;
      end
      ep_cmd_pkg::CMD_NORMAL:
      begin
        res.enable = 1'b1; // R10
        res.halt = 1'b0;
        res.force_nak = 1'b0;
      end
      ep_cmd_pkg::CMD_FORCE_NAK:
      begin
        res.enable = 1'b1; // R11
        res.halt = 1'b0;
        res.force_nak = 1'b1;
      end
      ep_cmd_pkg::CMD_TOGGLE_CLR: res.toggle = 1'b0; // R12
      ep_cmd_pkg::CMD_TOGGLE_SET: res.toggle = 1'b1; // R12
      ep_cmd_pkg::CMD_ISO_CLR: res.iso = 1'b0; // R13
      ep_cmd_pkg::CMD_ISO_SET: res.iso = 1'b1; // R13
      default: res = cur;
    endcase
    return res;
  endfunction : apply_cmd

  // Register file
  always_comb
  begin
    ctl_two_nxt = ctl_two_r;
    cmd_nxt = cmd_r;
    rdata_nxt = 8'h00;
    // Reserved bits stored as written; firmware keeps them zero
    if (wr_ctl_two)
      ctl_two_nxt = reg_wdata; // R4
    if (wr_cmd)
      cmd_nxt = reg_wdata; // R6
    if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_ENGINE_CONTROL_TWO: rdata_nxt = ctl_two_r;
        `ADDR_ENDPOINT_COMMAND: rdata_nxt = cmd_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    case (ctl_two_r[1:0])
      2'h0: iso_nxt = `ISO_CAP_CODE0; // R3
      2'h1: iso_nxt = `ISO_CAP_CODE1; // R3
      default: iso_nxt = `ISO_CAP_CODE2; // R3
    endcase
  end

  // Endpoint control sets; command wins over setup busy on same field
  genvar g;
  generate
    for (g = 0; g < NUM_EP; g++)
    begin : g_ep
      always_comb
      begin
        tx_nxt[g] = tx_r[g];
        rx_nxt[g] = rx_r[g];
        txb_nxt[g] = txb_r[g];
        rxb_nxt[g] = rxb_r[g];
        if (setup_rcvd && setup_ep == 4'(g)
            && ctl_two_r[`POS_SETUP_MARKS_BUSY])
        begin
          txb_nxt[g] = tx_r[g].enable; // R1
          rxb_nxt[g] = rx_r[g].enable; // R1
        end
        // Setup with feature off touches nothing
        if (wr_cmd && sel_ep == 4'(g))
        begin
          if (cmd_dir)
          begin
            tx_nxt[g] = apply_cmd(tx_r[g], cmd_code); // R5
            txb_nxt[g] = 1'b0;
          end
          else
          begin
            rx_nxt[g] = apply_cmd(rx_r[g], cmd_code); // R5
            rxb_nxt[g] = 1'b0;
          end
        end
      end
    end
  endgenerate

  // Handshake decision for an IN token
  always_comb
  begin
    hs_nxt = hs_r;
    if (in_token)
    begin
      if (!tx_r[in_ep].enable)
        hs_nxt = ep_cmd_pkg::HS_NONE; // R8
      else if (tx_r[in_ep].halt)
        hs_nxt = ep_cmd_pkg::HS_STALL; // R9
      else if (tx_r[in_ep].force_nak || txb_r[in_ep])
        hs_nxt = ep_cmd_pkg::HS_NAK; // R11
      else if (in_queue_has_data)
        hs_nxt = ep_cmd_pkg::HS_ACK; // R10
      else
        hs_nxt = ep_cmd_pkg::HS_NAK; // R10
    end
  end

  always_ff @(posedge core_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctl_two_r <= `RESET_ENGINE_CONTROL_TWO;
      cmd_r <= `RESET_ENDPOINT_COMMAND;
      rdata_r <= 8'h00;
      hs_r <= ep_cmd_pkg::HS_NONE;
      iso_r <= `ISO_CAP_CODE0;
      txb_r <= '0;
      rxb_r <= '0;
      tx_r <= '0;
      rx_r <= '0;
    end
    else
    begin
      ctl_two_r <= ctl_two_nxt;
      cmd_r <= cmd_nxt;
      rdata_r <= rdata_nxt;
      hs_r <= hs_nxt;
      iso_r <= iso_nxt;
      txb_r <= txb_nxt;
      rxb_r <= rxb_nxt;
      tx_r <= tx_nxt;
      rx_r <= rx_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign in_handshake = hs_r;
  assign iso_max_payload = iso_r;
  assign tx_busy = txb_r;
  assign rx_busy = rxb_r;
  assign tx_ctl = tx_r;
  assign rx_ctl = rx_r;

  sequence s_setup_on(logic [3:0] e);
    setup_rcvd && setup_ep == e && ctl_two_r[`POS_SETUP_MARKS_BUSY]
      && !wr_cmd;
  endsequence

  a_setup_busy_tx: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_setup_on(4'h0) |=> tx_busy[0] == $past(tx_r[0].enable)) // R1
    else $error("setup did not mark endpoint busy");

  a_setup_no_effect: assert property (@(posedge core_clk)
    disable iff (!rst_b)
    setup_rcvd && !ctl_two_r[`POS_SETUP_MARKS_BUSY] && !wr_cmd
      |=> $stable(tx_busy) && $stable(rx_busy) && $stable(tx_ctl)) // R2
    else $error("setup changed state with feature off");

  a_iso_cap_value: assert property (@(posedge core_clk) disable iff (!rst_b)
    ##1 iso_max_payload == (ctl_two_r[1] ? 11'h0f8 :
      ctl_two_r[0] ? 11'h1f8 : 11'h3ff) || $changed(ctl_two_r)) // R3
    else $error("iso cap wrong");

  a_cmd_single_dir: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_cmd && cmd_dir && !setup_rcvd |=> $stable(rx_ctl)) // R7
    else $error("transmit command touched receive side");

  a_cmd_disable: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_cmd && cmd_dir && sel_ep == 4'h0 && cmd_code == 3'h0
      ##1 in_token && in_ep == 4'h0 && !wr_cmd
      |=> in_handshake == ep_cmd_pkg::HS_NONE) // R8
    else $error("disabled endpoint handshaked");

  a_cmd_stall: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_cmd && cmd_dir && sel_ep == in_ep && cmd_code == 3'h1
      ##1 in_token && !wr_cmd |=> in_handshake == ep_cmd_pkg::HS_STALL) // R9
    else $error("halted endpoint did not stall");

  a_normal_ack: assert property (@(posedge core_clk) disable iff (!rst_b)
    in_token && tx_r[in_ep].enable && !tx_r[in_ep].halt
      && !tx_r[in_ep].force_nak && !txb_r[in_ep]
      |=> in_handshake == ($past(in_queue_has_data) ?
        ep_cmd_pkg::HS_ACK : ep_cmd_pkg::HS_NAK)) // R10
    else $error("normal handshake wrong");

  a_force_nak: assert property (@(posedge core_clk) disable iff (!rst_b)
    in_token && tx_r[in_ep].enable && !tx_r[in_ep].halt
      && tx_r[in_ep].force_nak |=> in_handshake == ep_cmd_pkg::HS_NAK) // R11
    else $error("forced nak not sent");

  a_toggle_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_cmd && !cmd_dir && cmd_code[2:1] == 2'h2
      |=> rx_ctl[$past(sel_ep)].toggle == $past(cmd_code[0])) // R12
    else $error("toggle command failed");

  a_iso_cmd: assert property (@(posedge core_clk) disable iff (!rst_b)
    wr_cmd && cmd_dir && cmd_code[2:1] == 2'h3
      |=> tx_ctl[$past(sel_ep)].iso == $past(cmd_code[0])) // R13 R14
    else $error("iso command failed");
endmodule : endpoint_command_control

// ### rtl/ep_cmd_consts.svh
`ifndef EP_CMD_CONSTS_SVH
`define EP_CMD_CONSTS_SVH
`define ADDR_ENGINE_CONTROL_TWO 16'h7fa9
`define ADDR_ENDPOINT_COMMAND 16'h7faa
`define RESET_ENGINE_CONTROL_TWO 8'h00
`define RESET_ENDPOINT_COMMAND 8'h00
`define POS_SETUP_MARKS_BUSY 2
`define POS_DIR 7
`define POS_CMD_LO 4
`define ISO_CAP_CODE0 11'h3ff
`define ISO_CAP_CODE1 11'h1f8
`define ISO_CAP_CODE2 11'h0f8
`endif

// ### rtl/ep_cmd_pkg.sv
package ep_cmd_pkg;
  typedef enum logic [2:0] {
    CMD_DISABLE = 3'h0,
    CMD_HALT = 3'h1,
    CMD_NORMAL = 3'h2,
    CMD_FORCE_NAK = 3'h3,
    CMD_TOGGLE_CLR = 3'h4,
    CMD_TOGGLE_SET = 3'h5,
    CMD_ISO_CLR = 3'h6,
    CMD_ISO_SET = 3'h7
  } ep_cmd_e;

  // Per direction control set of one endpoint
  typedef struct packed {
    logic iso;
    logic enable;
    logic halt;
    logic toggle;
    logic force_nak;
  } dir_ctl_s;

  typedef enum logic [1:0] {
    HS_NONE = 2'h0,
    HS_ACK = 2'h1,
    HS_NAK = 2'h2,
    HS_STALL = 2'h3
  } handshake_e;
endpackage : ep_cmd_pkg

// ### bench/usb_host_model.sv
`timescale 1ns/1ps
module usb_host_model (
  input wire logic core_clk,
  output logic setup_rcvd,
  output logic [3:0] setup_ep,
  output logic in_token,
  output logic [3:0] in_ep
);
  initial
  begin
    setup_rcvd = 1'b0;
    setup_ep = 4'h0;
    in_token = 1'b0;
    in_ep = 4'h0;
  end

  // Released lines show the inverse, never a stale endpoint
  task send_in(input logic [3:0] ep);
    @(posedge core_clk);
    in_token <= 1'b1;
    in_ep <= ep;
    @(posedge core_clk);
    in_token <= 1'b0;
    in_ep <= ~ep;
  endtask : send_in

  task send_setup(input logic [3:0] ep);
    @(posedge core_clk);
    setup_rcvd <= 1'b1;
    setup_ep <= ep;
    @(posedge core_clk);
    setup_rcvd <= 1'b0;
    setup_ep <= ~ep;
  endtask : send_setup
endmodule : usb_host_model

// ### bench/tb_usb_endpoint_command_control.sv
`timescale 1ns/1ps
`include "ep_cmd_consts.svh"
`define CHK(n, e, g) \
  begin \
    compares++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("MISMATCH %s exp %0h got %0h", n, e, g); \
    end \
  end
module tb_usb_endpoint_command_control;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [15:0] reg_addr = 16'h0000;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic in_queue_has_data = 1'b0;
  logic [7:0] reg_rdata;
  logic setup_rcvd;
  logic in_token;
  logic [3:0] setup_ep;
  logic [3:0] in_ep;
  logic [1:0] in_handshake;
  logic [10:0] iso_max_payload;
  logic [15:0] tx_busy;
  logic [15:0] rx_busy;
  ep_cmd_pkg::dir_ctl_s [15:0] tx_ctl;
  ep_cmd_pkg::dir_ctl_s [15:0] rx_ctl;
  logic [10:0] caps [4] = '{`ISO_CAP_CODE0, `ISO_CAP_CODE1,
    `ISO_CAP_CODE2, `ISO_CAP_CODE2};
  int errors = 0;
  int compares = 0;

  always #10 core_clk = ~core_clk;

  endpoint_command_control #(.NUM_EP(16)) endpoint_command_control_i (
    .core_clk(core_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .setup_rcvd(setup_rcvd), .setup_ep(setup_ep),
    .in_token(in_token), .in_ep(in_ep),
    .in_queue_has_data(in_queue_has_data), .in_handshake(in_handshake),
    .iso_max_payload(iso_max_payload), .tx_busy(tx_busy),
    .rx_busy(rx_busy), .tx_ctl(tx_ctl), .rx_ctl(rx_ctl));

  usb_host_model usb_host_model_i (
    .core_clk(core_clk), .setup_rcvd(setup_rcvd), .setup_ep(setup_ep),
    .in_token(in_token), .in_ep(in_ep));

  task wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask : wr

  task rd(input logic [15:0] a, input logic [7:0] e, input string n);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    `CHK(n, e, reg_rdata)
  endtask : rd

  // Whole constant with the endpoint ORed in, no read-modify-write
  task cmd(input logic dir, input logic [2:0] c, input logic [3:0] ep);
    wr(`ADDR_ENDPOINT_COMMAND, {dir, c, 4'h0} | {4'h0, ep});
  endtask : cmd

  task in_chk(input logic [3:0] ep, input logic q, input logic [1:0] e);
    @(posedge core_clk);
    in_queue_has_data <= q;
    usb_host_model_i.send_in(ep);
    #1;
    `CHK("handshake", e, in_handshake)
  endtask : in_chk

  task end_of_test;
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_of_test

  initial
  begin
    repeat (6) @(posedge core_clk);
    rst_b <= 1'b1;
    rd(`ADDR_ENGINE_CONTROL_TWO, `RESET_ENGINE_CONTROL_TWO, "ctl2");
    rd(`ADDR_ENDPOINT_COMMAND, `RESET_ENDPOINT_COMMAND, "cmd reg");
    `CHK("iso cap", `ISO_CAP_CODE0, iso_max_payload)
    rd(16'h0000, 8'h00, "unmapped");
    for (int i = 0; i < 4; i++)
    begin
      wr(`ADDR_ENGINE_CONTROL_TWO, i[7:0]);
      @(posedge core_clk);
      #1;
      `CHK("iso cap", caps[i], iso_max_payload)
    end
    rd(`ADDR_ENGINE_CONTROL_TWO, 8'h03, "ctl2");
    cmd(1'b1, ep_cmd_pkg::CMD_NORMAL, 4'h2);
    in_chk(4'h2, 1'b1, ep_cmd_pkg::HS_ACK);
    in_chk(4'h2, 1'b0, ep_cmd_pkg::HS_NAK);
    in_chk(4'h3, 1'b1, ep_cmd_pkg::HS_NONE);
    cmd(1'b1, ep_cmd_pkg::CMD_NORMAL, 4'hf);
    in_chk(4'hf, 1'b1, ep_cmd_pkg::HS_ACK);
    cmd(1'b1, ep_cmd_pkg::CMD_FORCE_NAK, 4'h2);
    in_chk(4'h2, 1'b1, ep_cmd_pkg::HS_NAK);
    cmd(1'b1, ep_cmd_pkg::CMD_HALT, 4'h2);
    in_chk(4'h2, 1'b1, ep_cmd_pkg::HS_STALL);
    cmd(1'b1, ep_cmd_pkg::CMD_DISABLE, 4'h2);
    in_chk(4'h2, 1'b1, ep_cmd_pkg::HS_NONE);
    cmd(1'b1, ep_cmd_pkg::CMD_TOGGLE_SET, 4'h2);
    `CHK("tx tog", 1'b1, tx_ctl[2].toggle)
    `CHK("rx tog", 1'b0, rx_ctl[2].toggle)
    cmd(1'b1, ep_cmd_pkg::CMD_TOGGLE_CLR, 4'h2);
    `CHK("tx tog", 1'b0, tx_ctl[2].toggle)
    cmd(1'b0, ep_cmd_pkg::CMD_TOGGLE_SET, 4'h2);
    `CHK("rx tog", 1'b1, rx_ctl[2].toggle)
    cmd(1'b1, ep_cmd_pkg::CMD_ISO_SET, 4'h2);
    `CHK("tx iso", 1'b1, tx_ctl[2].iso)
    `CHK("rx tog", 1'b1, rx_ctl[2].toggle)
    cmd(1'b1, ep_cmd_pkg::CMD_ISO_CLR, 4'h2);
    `CHK("tx iso", 1'b0, tx_ctl[2].iso)
    cmd(1'b1, ep_cmd_pkg::CMD_NORMAL, 4'h0);
    wr(`ADDR_ENGINE_CONTROL_TWO, 8'h00);
    usb_host_model_i.send_setup(4'h0);
    #1;
    `CHK("tx busy", 1'b0, tx_busy[0])
    wr(`ADDR_ENGINE_CONTROL_TWO, 8'h04);
    usb_host_model_i.send_setup(4'h0);
    #1;
    `CHK("tx busy", 1'b1, tx_busy[0])
    `CHK("rx busy", 1'b0, rx_busy[0])
    in_chk(4'h0, 1'b1, ep_cmd_pkg::HS_NAK);
    cmd(1'b1, ep_cmd_pkg::CMD_NORMAL, 4'h0);
    `CHK("tx busy", 1'b0, tx_busy[0])
    end_of_test;
  end

  // Whole run is under a hundred cycles; this leaves wide margin
  initial
  begin
    #200000;
    errors++;
    end_of_test;
  end
endmodule : tb_usb_endpoint_command_control
